// file: logic/charger_defs.svh
// Offsets, field positions, reset values and timing counts of the charger settings bank.
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_WD_CTRL 8'h01
`define OFS_PRE_TERM 8'h03
`define OFS_VCHG_TOP 8'h04
`define OFS_TERM_TMR 8'h05
`define OFS_INPUT_BST 8'h06
`define OFS_FAULT 8'h09
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_PRE_TERM 8'h22
`define RST_VCHG_TOP 8'h58
`define RST_TERM_TMR 8'h9F
`define RST_INPUT_BST 8'h66
// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_PRE 4
`define POS_TERM 0
`define POS_VCHG 3
`define POS_TOP 1
`define POS_RECHG 0
`define POS_TERM_EN 7
`define POS_WD 4
`define POS_TMR_EN 3
`define POS_TMR 2
`define POS_THERM 1
`define POS_COLD 0
`define POS_OVP 6
`define POS_BOOST 4
`define POS_VIN 0
`define POS_RESTART 6
`define POS_WD_FAULT 7
// ----------------------------------------
// Decode figures
// ----------------------------------------
`define PRE_MAX_CODE 4'hC
`define CUR_STEP_MA 10'h03C
`define VCHG_MAX_CODE 5'h18
`define VCHG_SPECIAL_CODE 5'h0F
`define VCHG_BASE_MV 13'h0F08
`define VCHG_STEP_MV 13'h0020
`define VCHG_SPECIAL_MV 13'h10F8
`define VIN_BASE_MV 13'h0F3C
`define VIN_STEP_MV 13'h0064
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define WD_TICK_TIME_S 1
`define WD_TICK_CYCLES (`CLK_HZ * `WD_TICK_TIME_S)
`define WD_PERIOD1_S 8'h28
`define WD_PERIOD2_S 8'h50
`define WD_PERIOD3_S 8'hA0
`endif

// file: logic/charger_pkg.sv
// Types shared by the charger settings bank.
package charger_pkg;
    typedef enum logic [2:0] {
        st_idle, st_addr, st_ptr, st_wdata, st_ack, st_read, st_rack
    } link_state_t;
endpackage : charger_pkg

// file: logic/charger_setting_decode.sv
// Turns the raw setting bytes into the physical targets used by the regulators.
`timescale 1ns/1ps
`include "charger_defs.svh"
module charger_setting_decode (
    input wire logic [7:0] i_pre_term,
    input wire logic [7:0] i_vchg_top,
    input wire logic [7:0] i_term_tmr,
    input wire logic [7:0] i_input_bst,
    output logic [9:0] o_precharge_ma,
    output logic [9:0] o_term_ma,
    output logic [12:0] o_charge_mv,
    output logic [5:0] o_topoff_min,
    output logic [7:0] o_recharge_mv,
    output logic [13:0] o_ovp_mv,
    output logic [12:0] o_boost_mv,
    output logic [12:0] o_vin_limit_mv
);
    logic [3:0] pre_code;
    logic [4:0] vchg_code;

    // Codes beyond the top step are clamped so a bad write cannot overdrive the cell.
    always_comb begin
        pre_code = i_pre_term[`POS_PRE+:4];
        if (pre_code > `PRE_MAX_CODE) begin
            pre_code = `PRE_MAX_CODE;
        end
        o_precharge_ma = `CUR_STEP_MA + 10'(pre_code) * `CUR_STEP_MA;
        o_term_ma = `CUR_STEP_MA + 10'(i_pre_term[`POS_TERM+:4]) * `CUR_STEP_MA;
        vchg_code = i_vchg_top[`POS_VCHG+:5];
        if (vchg_code > `VCHG_MAX_CODE) begin
            vchg_code = `VCHG_MAX_CODE;
        end
        if (vchg_code == `VCHG_SPECIAL_CODE) begin
            o_charge_mv = `VCHG_SPECIAL_MV;
        end else begin
            o_charge_mv = `VCHG_BASE_MV + 13'(vchg_code) * `VCHG_STEP_MV;
        end
        // Code 01 is undocumented; it is read as no extension.
        unique case (i_vchg_top[`POS_TOP+:2])
            2'h2: o_topoff_min = 6'h1E;
            2'h3: o_topoff_min = 6'h2D;
            default: o_topoff_min = 6'h00;
        endcase
        o_recharge_mv = i_vchg_top[`POS_RECHG] ? 8'hC8 : 8'h64;
        unique case (i_input_bst[`POS_OVP+:2])
            2'h0: o_ovp_mv = 14'h157C;
            2'h1: o_ovp_mv = 14'h1964;
            2'h2: o_ovp_mv = 14'h2904;
            default: o_ovp_mv = 14'h36B0;
        endcase
        unique case (i_input_bst[`POS_BOOST+:2])
            2'h0: o_boost_mv = 13'h12F2;
            2'h1: o_boost_mv = 13'h1388;
            2'h2: o_boost_mv = 13'h141E;
            default: o_boost_mv = 13'h14B4;
        endcase
        o_vin_limit_mv = `VIN_BASE_MV + 13'(i_input_bst[`POS_VIN+:4]) * `VIN_STEP_MV;
    end
endmodule : charger_setting_decode

// file: logic/host_watchdog.sv
// Host watchdog: counts whole seconds and flags an expiry when the host stays silent.
`timescale 1ns/1ps
`include "charger_defs.svh"
module host_watchdog #(
    parameter int TICK_CYCLES = `WD_TICK_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [1:0] i_period_code,
    input wire logic i_restart,
    output logic o_expire
);
    typedef struct packed {
        logic [31:0] tick;
        logic [7:0] secs;
        logic expire;
    } wd_state_t;

    wd_state_t s_r;
    wd_state_t s_nxt;
    logic [7:0] period_s;

    if (TICK_CYCLES < 1) begin : g_chk
        $error("TICK_CYCLES must be at least one");
    end

    // Period in seconds; zero means the watchdog is off.
    always_comb begin
        unique case (i_period_code)
            2'h0: period_s = 8'h00;
            2'h1: period_s = `WD_PERIOD1_S;
            2'h2: period_s = `WD_PERIOD2_S;
            default: period_s = `WD_PERIOD3_S;
        endcase
    end

    // A restart or a disabled period clears both counters.
    always_comb begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (i_restart || period_s == 8'h00) begin
            s_nxt.tick = 32'h0;
            s_nxt.secs = 8'h00;
        end else if (s_r.tick >= 32'(TICK_CYCLES - 1)) begin
            s_nxt.tick = 32'h0;
            // Compare with >= so that shortening the period mid-run still expires.
            if (s_r.secs + 8'h01 >= period_s) begin
                s_nxt.secs = 8'h00;
                s_nxt.expire = 1'b1;
            end else begin
                s_nxt.secs = s_r.secs + 8'h01;
            end
        end else begin
            s_nxt.tick = s_r.tick + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_expire = s_r.expire;
endmodule : host_watchdog

// file: logic/charger_config_registers.sv
// Charger settings bank reached over the two-wire serial bus, with host watchdog.
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
`include "charger_defs.svh"
module charger_config_registers #(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // Arbitrary value.
    parameter int TICK_CYCLES = `WD_TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_reg_reset,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [9:0] o_precharge_ma,
    output logic [9:0] o_term_ma,
    output logic [12:0] o_charge_mv,
    output logic [5:0] o_topoff_min,
    output logic [7:0] o_recharge_mv,
    output logic o_term_enable,
    output logic o_safety_timer_enable,
    output logic [3:0] o_safety_timer_hours,
    output logic o_thermal_limit_select,
    output logic o_cold_current_scale,
    output logic [13:0] o_ovp_mv,
    output logic [12:0] o_boost_mv,
    output logic [12:0] o_vin_limit_mv,
    output logic o_watchdog_fault
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        charger_pkg::link_state_t st;
        charger_pkg::link_state_t after;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic sda_oe;
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic [7:0] pre_term;
        logic [7:0] vchg_top;
        logic [7:0] term_tmr;
        logic [7:0] input_bst;
        logic restart;
        logic fault;
        logic [9:0] precharge_ma;
        logic [9:0] term_ma;
        logic [12:0] charge_mv;
        logic [5:0] topoff_min;
        logic [7:0] recharge_mv;
        logic [13:0] ovp_mv;
        logic [12:0] boost_mv;
        logic [12:0] vin_limit_mv;
    } top_state_t;

    top_state_t s_r;
    top_state_t s_nxt;
    logic rst_meta_r;
    logic rst_n_r;
    logic expire;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [9:0] dec_pre_ma;
    logic [9:0] dec_term_ma;
    logic [12:0] dec_charge_mv;
    logic [5:0] dec_topoff_min;
    logic [7:0] dec_recharge_mv;
    logic [13:0] dec_ovp_mv;
    logic [12:0] dec_boost_mv;
    logic [12:0] dec_vin_mv;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Read view of the map; unmapped offsets read as zero.
    function automatic logic [7:0] read_byte(input top_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (s.ptr)
            `OFS_WD_CTRL: v[`POS_RESTART] = s.restart;
            `OFS_PRE_TERM: v = s.pre_term;
            `OFS_VCHG_TOP: v = s.vchg_top;
            `OFS_TERM_TMR: v = s.term_tmr;
            `OFS_INPUT_BST: v = s.input_bst;
            `OFS_FAULT: v[`POS_WD_FAULT] = s.fault;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_byte

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // The reset is released through two flops so every flop leaves reset on one edge.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    host_watchdog #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_watchdog (
        .i_clk(i_core_clk),
        .i_rst_n(rst_n_r),
        .i_period_code(s_r.term_tmr[`POS_WD+:2]),
        .i_restart(s_r.restart),
        .o_expire(expire)
    );

    charger_setting_decode u_decode (
        .i_pre_term(s_r.pre_term),
        .i_vchg_top(s_r.vchg_top),
        .i_term_tmr(s_r.term_tmr),
        .i_input_bst(s_r.input_bst),
        .o_precharge_ma(dec_pre_ma),
        .o_term_ma(dec_term_ma),
        .o_charge_mv(dec_charge_mv),
        .o_topoff_min(dec_topoff_min),
        .o_recharge_mv(dec_recharge_mv),
        .o_ovp_mv(dec_ovp_mv),
        .o_boost_mv(dec_boost_mv),
        .o_vin_limit_mv(dec_vin_mv)
    );

    // Bus events come only from the second synchroniser stage and its delayed copy.
    assign scl_rise = s_r.scl_s2 & ~s_r.scl_d;
    assign scl_fall = ~s_r.scl_s2 & s_r.scl_d;
    assign start_seen = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_s2 & s_r.sda_d;
    assign stop_seen = s_r.scl_s2 & s_r.scl_d & s_r.sda_s2 & ~s_r.sda_d;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_s1 = i_scl;
        s_nxt.scl_s2 = s_r.scl_s1;
        s_nxt.scl_d = s_r.scl_s2;
        s_nxt.sda_s1 = i_sda;
        s_nxt.sda_s2 = s_r.sda_s1;
        s_nxt.sda_d = s_r.sda_s2;
        // The watchdog samples the restart bit once, so it is dropped a cycle later.
        s_nxt.restart = 1'b0;

        // Serial bus target; start and stop override any byte in flight.
        if (start_seen) begin
            s_nxt.st = charger_pkg::st_addr;
            s_nxt.cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end else if (stop_seen) begin
            s_nxt.st = charger_pkg::st_idle;
            s_nxt.sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (s_r.st)
                charger_pkg::st_addr, charger_pkg::st_ptr, charger_pkg::st_wdata: begin
                    s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
                    s_nxt.cnt = s_r.cnt + 4'h1;
                end
                charger_pkg::st_rack: begin
                    // A not-acknowledge ends the read burst.
                    if (s_r.sda_s2) begin
                        s_nxt.st = charger_pkg::st_idle;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (s_r.st)
                charger_pkg::st_addr: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.cnt = 4'h0;
                        if (s_r.sh[7:1] == DEV_ADDR) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.st = charger_pkg::st_ack;
                            s_nxt.after = s_r.sh[0] ? charger_pkg::st_read : charger_pkg::st_ptr;
                        end else begin
                            s_nxt.st = charger_pkg::st_idle;
                        end
                    end
                end
                charger_pkg::st_ptr: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.ptr = s_r.sh;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = charger_pkg::st_ack;
                        s_nxt.after = charger_pkg::st_wdata;
                    end
                end
                charger_pkg::st_wdata: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.cnt = 4'h0;
                        s_nxt.ptr = s_r.ptr + 8'h01;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = charger_pkg::st_ack;
                        s_nxt.after = charger_pkg::st_wdata;
                        unique case (s_r.ptr)
                            `OFS_WD_CTRL: s_nxt.restart = s_r.sh[`POS_RESTART];
                            `OFS_PRE_TERM: s_nxt.pre_term = s_r.sh;
                            `OFS_VCHG_TOP: s_nxt.vchg_top = s_r.sh;
                            `OFS_TERM_TMR: s_nxt.term_tmr = s_r.sh;
                            `OFS_INPUT_BST: s_nxt.input_bst = s_r.sh;
                            default: begin
                            end
                        endcase
                    end
                end
                charger_pkg::st_ack, charger_pkg::st_rack: begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.st = (s_r.st == charger_pkg::st_rack) ? charger_pkg::st_read
                                                                  : s_r.after;
                    if (s_r.st == charger_pkg::st_rack || s_r.after == charger_pkg::st_read) begin
                        // Load the byte and present its top bit at once.
                        s_nxt.sh = read_byte(s_r) << 1;
                        s_nxt.sda_oe = read_byte(s_r) < 8'h80;
                        s_nxt.cnt = 4'h1;
                        s_nxt.ptr = s_r.ptr + 8'h01;
                        if (s_r.ptr == `OFS_FAULT) begin
                            s_nxt.fault = 1'b0;
                        end
                    end
                end
                charger_pkg::st_read: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = charger_pkg::st_rack;
                    end else begin
                        s_nxt.sda_oe = ~s_r.sh[7];
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end

        // A restore wins over a host write landing in the same cycle.
        if (i_reg_reset || expire) begin
            s_nxt.pre_term = `RST_PRE_TERM;
            s_nxt.vchg_top = `RST_VCHG_TOP;
            s_nxt.term_tmr = `RST_TERM_TMR;
            s_nxt.restart = 1'b0;
        end
        // The input protection byte is only restored by a register reset.
        if (i_reg_reset) begin
            s_nxt.input_bst = `RST_INPUT_BST;
        end
        // Expiry is set after the read clear, so a coincident expiry is kept.
        if (expire) begin
            s_nxt.fault = 1'b1;
        end

        // Decoded targets from the decode module are registered so each of their outputs leaves a flop.
        s_nxt.precharge_ma = dec_pre_ma;
        s_nxt.term_ma = dec_term_ma;
        s_nxt.charge_mv = dec_charge_mv;
        s_nxt.topoff_min = dec_topoff_min;
        s_nxt.recharge_mv = dec_recharge_mv;
        s_nxt.ovp_mv = dec_ovp_mv;
        s_nxt.boost_mv = dec_boost_mv;
        s_nxt.vin_limit_mv = dec_vin_mv;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Bus lines reset high so that release is not mistaken for a start.
    always_ff @(posedge i_core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            s_r <= '0;
            s_r.st <= charger_pkg::st_idle;
            s_r.after <= charger_pkg::st_idle;
            s_r.scl_s1 <= 1'b1;
            s_r.scl_s2 <= 1'b1;
            s_r.scl_d <= 1'b1;
            s_r.sda_s1 <= 1'b1;
            s_r.sda_s2 <= 1'b1;
            s_r.sda_d <= 1'b1;
            s_r.pre_term <= `RST_PRE_TERM;
            s_r.vchg_top <= `RST_VCHG_TOP;
            s_r.term_tmr <= `RST_TERM_TMR;
            s_r.input_bst <= `RST_INPUT_BST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_sda_out = 1'b0; // Open drain: only ever pulls low.
    assign o_sda_oe = s_r.sda_oe;
    assign o_precharge_ma = s_r.precharge_ma;
    assign o_term_ma = s_r.term_ma;
    assign o_charge_mv = s_r.charge_mv;
    assign o_topoff_min = s_r.topoff_min;
    assign o_recharge_mv = s_r.recharge_mv;
    assign o_term_enable = s_r.term_tmr[`POS_TERM_EN];
    assign o_safety_timer_enable = s_r.term_tmr[`POS_TMR_EN];
    assign o_safety_timer_hours = s_r.term_tmr[`POS_TMR] ? 4'hA : 4'h5;
    assign o_thermal_limit_select = s_r.term_tmr[`POS_THERM];
    assign o_cold_current_scale = s_r.term_tmr[`POS_COLD];
    assign o_ovp_mv = s_r.ovp_mv;
    assign o_boost_mv = s_r.boost_mv;
    assign o_vin_limit_mv = s_r.vin_limit_mv;
    assign o_watchdog_fault = s_r.fault;
endmodule : charger_config_registers

// file: tb/charger_config_registers_chk.sv
// Port assertions for the charger settings bank.
`timescale 1ns/1ps
module charger_config_registers_chk (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_reg_reset,
    input wire logic [9:0] o_precharge_ma,
    input wire logic [12:0] o_charge_mv,
    input wire logic [5:0] o_topoff_min,
    input wire logic [3:0] o_safety_timer_hours,
    input wire logic [13:0] o_ovp_mv,
    input wire logic [12:0] o_vin_limit_mv,
    input wire logic o_watchdog_fault
);
    // ----
    // Properties
    // ----
    // Decoded outputs are zero just after reset, so zero is accepted.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);
    property p_pre_max; o_precharge_ma <= 10'h30C; endproperty
    a_pre_max: assert property (p_pre_max) else $error("precharge above top");
    property p_chg; o_charge_mv <= 13'h1208 && o_charge_mv != 13'h10E8; endproperty
    a_chg: assert property (p_chg) else $error("charge target bad");
    property p_hours; o_safety_timer_hours inside {4'h5, 4'hA}; endproperty
    a_hours: assert property (p_hours) else $error("timer hours bad");
    property p_topoff; o_topoff_min inside {6'h00, 6'h1E, 6'h2D}; endproperty
    a_topoff: assert property (p_topoff) else $error("top-off bad");
    property p_vin; o_vin_limit_mv inside {13'h0000, [13'h0F3C:13'h1518]}; endproperty
    a_vin: assert property (p_vin) else $error("input limit bad");
    property p_ovp; o_ovp_mv inside {14'h0000, 14'h157C, 14'h1964, 14'h2904, 14'h36B0}; endproperty
    a_ovp: assert property (p_ovp) else $error("ovp bad");
    // The decode lags the register by one clock, hence two clocks after the pulse.
    property p_regrst;
        i_reg_reset |-> ##2 (o_precharge_ma == 10'h0B4 && o_charge_mv == 13'h1068
            && o_ovp_mv == 14'h1964 && o_vin_limit_mv == 13'h1194);
    endproperty
    a_regrst: assert property (p_regrst) else $error("register reset missed");
    property p_wd;
        $rose(o_watchdog_fault) |-> ##[1:2] (o_precharge_ma == 10'h0B4 && o_charge_mv == 13'h1068);
    endproperty
    a_wd: assert property (p_wd) else $error("expiry restore missed");
    c_regrst: cover property (i_reg_reset);
    c_fault: cover property ($rose(o_watchdog_fault));
    c_special: cover property (o_charge_mv == 13'h10F8);
endmodule : charger_config_registers_chk

// file: tb/charger_host_model.sv
// Host model that masters the two-wire bus with open-drain data.
`timescale 1ns/1ps
module charger_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value.
) (
    input wire logic i_clk,
    input wire logic i_dev_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic host_low = 1'b0;
    initial o_scl = 1'b1;
    // Both sides only pull low; released, the pull-up reads one.
    assign o_sda = ~(host_low | i_dev_sda_oe);
    // A third of a bit, 8 clocks, covers the device's late answer.
    task automatic gap();
        repeat (8) @(negedge i_clk);
    endtask : gap
    // Data moves only while the clock is low: no false start or stop.
    task automatic bit_io(input logic b, output logic got);
        host_low = ~b;
        gap();
        o_scl = 1'b1;
        gap();
        got = o_sda;
        o_scl = 1'b0;
        gap();
    endtask : bit_io
    task automatic byte_io(input logic [7:0] tx, input logic ack_in,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ack_in, ack);
    endtask : byte_io
    // Start (or repeated start) when set, stop otherwise.
    task automatic cond(input logic start);
        host_low = ~start;
        gap();
        o_scl = 1'b1;
        gap();
        host_low = start;
        gap();
        o_scl = ~start;
        gap();
    endtask : cond
    task automatic write_reg(input logic [6:0] adr, input logic [7:0] ofs,
        input logic [7:0] val, output logic nak);
        logic [7:0] rx;
        logic a0, a1, a2;
        cond(1'b1);
        byte_io({adr, 1'b0}, 1'b1, rx, a0);
        byte_io(ofs, 1'b1, rx, a1);
        byte_io(val, 1'b1, rx, a2);
        cond(1'b0);
        nak = a0 | a1 | a2;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val, output logic nak);
        logic [7:0] rx;
        logic a0, a1, a2, a3;
        cond(1'b1);
        byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
        byte_io(ofs, 1'b1, rx, a1);
        cond(1'b1);
        byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
        byte_io(8'hFF, 1'b1, val, a3);
        cond(1'b0);
        nak = a0 | a1 | a2;
    endtask : read_reg
endmodule : charger_host_model

// file: tb/charger_config_registers_test.sv
// Self-checking bench for the charger settings bank.
`timescale 1ns/1ps
module charger_config_registers_test;
    localparam int TICK = 400;
    localparam logic [6:0] ADDR = 7'h2A; // Arbitrary value.
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_reg_reset = 1'b0;
    logic i_scl, i_sda, o_sda_out, o_sda_oe, o_term_enable, o_safety_timer_enable;
    logic o_thermal_limit_select, o_cold_current_scale, o_watchdog_fault, nak;
    logic [9:0] o_precharge_ma, o_term_ma;
    logic [12:0] o_charge_mv, o_boost_mv, o_vin_limit_mv;
    logic [5:0] o_topoff_min;
    logic [7:0] o_recharge_mv, rd;
    logic [3:0] o_safety_timer_hours;
    logic [13:0] o_ovp_mv;
    int n_fail = 0;
    int samples_checked = 0;
    logic [7:0] rst_val [4] = '{8'h22, 8'h58, 8'h9F, 8'h66};
    // Rows: offset, data, output picked, expected value.
    logic [35:0] rows [23] = '{
        36'h0508_8_0054, 36'h0587_8_00AB,
        36'h03F0_0_030C, 36'h030F_0_003C,
        36'h03BF_1_03C0, 36'h0400_2_0F08,
        36'h0478_2_10F8, 36'h04FF_2_1208,
        36'h04FF_3_002D, 36'h04FD_3_001E,
        36'h0400_3_0000, 36'h0401_4_00C8,
        36'h0400_4_0064, 36'h0600_5_157C,
        36'h0640_5_1964, 36'h0680_5_2904,
        36'h06C0_5_36B0, 36'h0600_6_12F2,
        36'h0610_6_1388, 36'h0620_6_141E,
        36'h0630_6_14B4, 36'h060F_7_1518,
        36'h0600_7_0F3C};
    // 20 ns half period: 25 MHz.
    always #20 i_core_clk = ~i_core_clk;
    charger_config_registers #(.DEV_ADDR(ADDR), .TICK_CYCLES(TICK)) charger_config_registers_inst (
        .i_core_clk, .i_nrst, .i_scl, .i_sda, .i_reg_reset, .o_sda_out, .o_sda_oe,
        .o_precharge_ma, .o_term_ma, .o_charge_mv, .o_topoff_min, .o_recharge_mv,
        .o_term_enable, .o_safety_timer_enable, .o_safety_timer_hours,
        .o_thermal_limit_select, .o_cold_current_scale, .o_ovp_mv, .o_boost_mv,
        .o_vin_limit_mv, .o_watchdog_fault);
    charger_host_model #(.DEV_ADDR(ADDR)) charger_host_model_inst (
        .i_clk(i_core_clk), .i_dev_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda));
    function automatic logic [15:0] pick(input logic [3:0] k);
        case (k)
            4'h0: pick = 16'(o_precharge_ma);
            4'h1: pick = 16'(o_term_ma);
            4'h2: pick = 16'(o_charge_mv);
            4'h3: pick = 16'(o_topoff_min);
            4'h4: pick = 16'(o_recharge_mv);
            4'h5: pick = 16'(o_ovp_mv);
            4'h6: pick = 16'(o_boost_mv);
            4'h7: pick = 16'(o_vin_limit_mv);
            default: pick = {8'h00, o_term_enable, o_safety_timer_enable,
                o_safety_timer_hours, o_thermal_limit_select, o_cold_current_scale};
        endcase
    endfunction : pick
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rd_reg(input logic [7:0] ofs);
        charger_host_model_inst.read_reg(ofs, rd, nak);
    endtask : rd_reg
    task automatic check_defaults();
        for (int i = 0; i < 4; i++) begin
            rd_reg(8'h03 + 8'(i));
            check(16'(rd), 16'(rst_val[i]));
        end
    endtask : check_defaults
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Main sequence; the first row turns the watchdog off.
    initial begin
        repeat (4) @(negedge i_core_clk);
        i_nrst = 1'b1;
        repeat (6) @(negedge i_core_clk);
        check_defaults();
        foreach (rows[i]) begin
            charger_host_model_inst.write_reg(ADDR, rows[i][35:28], rows[i][27:20], nak);
            check(pick(rows[i][19:16]) | 16'(nak), rows[i][15:0]);
            rd_reg(rows[i][35:28]);
            check({7'h00, nak, rd}, 16'(rows[i][27:20]));
        end
        charger_host_model_inst.write_reg(7'h2B, 8'h03, 8'h00, nak);
        check(16'(nak), 16'h0001);
        check(pick(4'h0), 16'h02D0);
        rd_reg(8'h0A);
        check(16'(rd), 16'h0000);
        @(negedge i_core_clk) i_reg_reset = 1'b1;
        @(negedge i_core_clk) i_reg_reset = 1'b0;
        check_defaults();
        charger_host_model_inst.write_reg(ADDR, 8'h03, 8'hF0, nak);
        charger_host_model_inst.write_reg(ADDR, 8'h06, 8'hC0, nak);
        charger_host_model_inst.write_reg(ADDR, 8'h01, 8'h40, nak);
        rd_reg(8'h01);
        check(16'(rd), 16'h0000);
        repeat (34 * TICK) @(negedge i_core_clk);
        check(16'(o_watchdog_fault), 16'h0000);
        repeat (8 * TICK) @(negedge i_core_clk);
        check(16'(o_watchdog_fault), 16'h0001);
        check(pick(4'h0), 16'h00B4);
        check(pick(4'h5), 16'h36B0);
        rd_reg(8'h09);
        check(16'(rd), 16'h0080);
        report_and_stop();
    end
    // Stops a hang.
    initial begin
        #3_600_000;
        n_fail++;
        report_and_stop();
    end
endmodule : charger_config_registers_test
bind charger_config_registers charger_config_registers_chk charger_config_registers_chk_inst (
    .i_core_clk, .i_nrst, .i_reg_reset, .o_precharge_ma, .o_charge_mv, .o_topoff_min,
    .o_safety_timer_hours, .o_ovp_mv, .o_vin_limit_mv, .o_watchdog_fault);
